// ===== design/gamma_pkg.sv
// Notes on behaviour
// RULE1: answers only on the strapped slave address and the general call address
// RULE2: address low bit follows address select pin
// RULE3: output voltage is supply times code over 1024
// RULE4: each channel code is ten bits wide
// RULE5: immediate mode updates output after write
// RULE6: deferred mode stages codes, applies all together
// RULE7: general call reset loads mid-scale code
// RULE8: host reads back every channel register
// RULE9: host programs a one-time store
package gamma_pkg;
    localparam int          NUM_CH      = 24;
    localparam int          CODE_W      = 10;
    localparam int          PTR_W       = 5;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;      // data bits before the ack slot
    localparam logic [5:0]  ADDR_HI     = 6'h3A;     // arbitrary upper address bits
    localparam logic [9:0]  MID_CODE    = 10'h200;
    localparam logic [7:0]  GC_ADDR     = 8'h00;
    localparam logic [7:0]  GC_RESET    = 8'h06;
    // pointer byte: bit7 immediate, bit6 apply-all, bit5 otp program, 4:0 channel
    localparam int          PB_IMM      = 7;
    localparam int          PB_APPLY    = 6;
    localparam int          PB_OTP      = 5;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TACK
    } i2c_state_t;
endpackage

// ===== design/sync2.sv
`timescale 1ns/100ps
module sync2 (
    input  wire logic clk_in,      // clock
    input  wire logic srst_in,     // reset
    input  wire logic d_in,        // async level
    output logic      q_out        // synchronised level
);
    logic s1_q;
    logic s2_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
        end
    end
    assign q_out = s2_q;
endmodule

// ===== design/gamma_i2c_regs.sv
`timescale 1ns/100ps
module gamma_i2c_regs (
    input  wire logic        clk_in,                 // 250 MHz clock
    input  wire logic        srst_in,                // sync reset, high
    input  wire logic        scl_in,                 // i2c clock pin
    input  wire logic        sda_in,                 // i2c data pin level
    output logic             sda_out,                // data drive value (0)
    output logic             sda_oe_out,             // high while pulling sda low
    input  wire logic        address_select_pin_in,  // strap for address bit 0
    output logic [239:0]     dac_code_out,           // active codes, ch0 in low bits
    output logic             otp_prog_out            // one-cycle otp burn pulse
);
    localparam int N = gamma_pkg::NUM_CH;
    localparam int W = gamma_pkg::CODE_W;

    ////////////////////////////////////////////////////////////////
    // pins cross two flops before any logic reads them
    logic scl_s;
    logic sda_s;
    logic asel_s;
    sync2 u_scl  (.clk_in(clk_in), .srst_in(srst_in), .d_in(scl_in),  .q_out(scl_s));
    sync2 u_sda  (.clk_in(clk_in), .srst_in(srst_in), .d_in(sda_in),  .q_out(sda_s));
    sync2 u_asel (.clk_in(clk_in), .srst_in(srst_in), .d_in(address_select_pin_in),
                  .q_out(asel_s));

    // edge history resets high, the idle bus level, so no false edge
    logic scl_p_q;
    logic sda_p_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

    ////////////////////////////////////////////////////////////////
    gamma_pkg::i2c_state_t st_q, st_d;
    logic [7:0]     sh_q, sh_d;
    logic [3:0]     bit_q, bit_d;
    logic           rd_q, rd_d;
    logic           gc_q, gc_d;
    logic [1:0]     byte_q, byte_d;     // write byte phase: 0 pointer next, 1 high code byte next, 2 low code byte next
    logic [7:0]     ptr_q, ptr_d;
    logic [7:0]     hi_q, hi_d;
    logic           ack_q, ack_d;       // we drive ack this bit
    logic           drv_q, drv_d;       // sda pulled low
    logic           hi_nxt_q, hi_nxt_d; // read: high byte next
    logic [W-1:0]   stage_q [N];        // written codes
    logic [W-1:0]   act_q   [N];        // codes seen at outputs
    logic [W-1:0]   stage_d [N];
    logic [W-1:0]   act_d   [N];
    logic           otp_d, otp_q;

    // strap is followed live, so moving it retargets the next frame
    wire [6:0] my_addr = {gamma_pkg::ADDR_HI, asel_s};  // RULE1 RULE2
    wire [4:0] ch      = ptr_q[gamma_pkg::PTR_W-1:0];
    // channels past the last one: writes dropped, reads give zero
    wire       ch_ok   = {3'h0, ch} < 8'(N);

    always_comb begin
        // hold everything but the otp pulse, which clears, unless an event below moves it
        st_d     = st_q;
        sh_d     = sh_q;
        bit_d    = bit_q;
        rd_d     = rd_q;
        gc_d     = gc_q;
        byte_d   = byte_q;
        ptr_d    = ptr_q;
        hi_d     = hi_q;
        ack_d    = ack_q;
        drv_d    = drv_q;
        hi_nxt_d = hi_nxt_q;
        otp_d    = 1'h0;
        stage_d  = stage_q;
        act_d    = act_q;
        if (start_c) begin
            st_d   = gamma_pkg::ST_ADDR;
            bit_d  = 4'h0;
            drv_d  = 1'h0;
            byte_d = 2'h0;
        end else if (stop_c) begin
            st_d  = gamma_pkg::ST_IDLE;
            drv_d = 1'h0;
        end else begin
            case (st_q)
            gamma_pkg::ST_ADDR, gamma_pkg::ST_RX: begin
                if (scl_rise) begin
                    sh_d  = {sh_q[6:0], sda_s};
                    bit_d = bit_q + 4'h1;
                end else if (scl_fall && bit_q == gamma_pkg::BYTE_BITS) begin
                    bit_d = 4'h0;
                    ack_d = 1'b0;
                    if (st_q == gamma_pkg::ST_ADDR) begin
                        gc_d = (sh_q == gamma_pkg::GC_ADDR);
                        rd_d = sh_q[0];
                        if (sh_q[7:1] == my_addr || gc_d) ack_d = 1'b1;  // RULE1
                        hi_nxt_d = 1'b1;
                    end else begin
                        ack_d = 1'b1;
                        if (gc_q) begin
                            if (sh_q == gamma_pkg::GC_RESET) begin
                                for (int i = 0; i < N; i++) begin
                                    stage_d[i] = gamma_pkg::MID_CODE;  // RULE7
                                    act_d[i]   = gamma_pkg::MID_CODE;  // RULE7
                                end
                            end
                        end else if (byte_q == 2'h0) begin
                            ptr_d = sh_q;
                            if (sh_q[gamma_pkg::PB_APPLY])
                                act_d = stage_q;                       // RULE6
                            if (sh_q[gamma_pkg::PB_OTP]) otp_d = 1'b1; // RULE9
                            byte_d = 2'h1;
                        end else if (byte_q == 2'h1) begin
                            hi_d = sh_q;
                            byte_d = 2'h2;
                        end else begin
                            if (ch_ok) begin
                                stage_d[ch] = {hi_q[1:0], sh_q};       // RULE4
                                if (ptr_q[gamma_pkg::PB_IMM])
                                    act_d[ch] = {hi_q[1:0], sh_q};     // RULE5 RULE3
                            end
                            ptr_d = {ptr_q[7:gamma_pkg::PTR_W], ch + 5'h1};
                            byte_d = 2'h1;
                        end
                    end
                    drv_d = ack_d;
                    st_d  = ack_d ? gamma_pkg::ST_ACK : gamma_pkg::ST_IDLE;
                end
            end
            gamma_pkg::ST_ACK: begin
                if (scl_fall) begin
                    drv_d = 1'b0;
                    if (rd_q && byte_q == 2'h0 && !gc_q) begin
                        // ch_ok false reads zero; RULE8
                        sh_d = hi_nxt_q ? {6'h00, ch_ok ? stage_q[ch][W-1:8] : 2'h0}
                                        : (ch_ok ? stage_q[ch][7:0] : 8'h00);
                        drv_d = ~sh_d[7];
                        bit_d = 4'h1;
                        st_d = gamma_pkg::ST_TX;
                    end else begin
                        st_d = gamma_pkg::ST_RX;
                    end
                end
            end
            gamma_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (bit_q == gamma_pkg::BYTE_BITS) begin
                        drv_d = 1'b0;
                        st_d = gamma_pkg::ST_TACK;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b0};
                        drv_d = ~sh_q[6];
                        bit_d = bit_q + 4'h1;
                    end
                end
            end
            gamma_pkg::ST_TACK: begin
                if (scl_rise) begin
                    if (sda_s) st_d = gamma_pkg::ST_IDLE;  // host nack ends read
                    else begin
                        if (!hi_nxt_q) ptr_d = {ptr_q[7:gamma_pkg::PTR_W], ch + 5'h1};
                        hi_nxt_d = ~hi_nxt_q;
                        st_d = gamma_pkg::ST_ACK;
                    end
                end
            end
            default: st_d = gamma_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_q     <= gamma_pkg::ST_IDLE;
            sh_q     <= 8'h00;
            bit_q    <= 4'h0;
            rd_q     <= 1'h0;
            gc_q     <= 1'h0;
            byte_q   <= 2'h0;
            ptr_q    <= 8'h00;
            hi_q     <= 8'h00;
            ack_q    <= 1'h0;
            drv_q    <= 1'h0;
            hi_nxt_q <= 1'h1;
            otp_q    <= 1'h0;
            for (int i = 0; i < N; i++) begin
                stage_q[i] <= gamma_pkg::MID_CODE;
                act_q[i]   <= gamma_pkg::MID_CODE;
            end
        end else begin
            st_q     <= st_d;
            sh_q     <= sh_d;
            bit_q    <= bit_d;
            rd_q     <= rd_d;
            gc_q     <= gc_d;
            byte_q   <= byte_d;
            ptr_q    <= ptr_d;
            hi_q     <= hi_d;
            ack_q    <= ack_d;
            drv_q    <= drv_d;
            hi_nxt_q <= hi_nxt_d;
            otp_q    <= otp_d;
            stage_q  <= stage_d;
            act_q    <= act_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < N; i++) dac_code_out[i*W +: W] = act_q[i];  // RULE3
    end
    // open drain: only ever pulls low, the pull-up gives the high
    assign sda_out      = 1'b0;
    assign sda_oe_out   = drv_q;
    assign otp_prog_out = otp_q;  // RULE9
endmodule

// ===== verif/gamma_i2c_regs_monitor.sv
`timescale 1ns/100ps
module gamma_i2c_regs_monitor (
    input wire logic         clk_in,                // clock
    input wire logic         srst_in,               // reset
    input wire logic         scl_in,                // scl
    input wire logic         sda_in,                // sda
    input wire logic         sda_out,               // drive value
    input wire logic         sda_oe_out,            // drive enable
    input wire logic         address_select_pin_in, // strap
    input wire logic [239:0] dac_code_out,          // codes
    input wire logic         otp_prog_out           // otp pulse
);
    default clocking @(posedge clk_in); endclocking
    a_reset_mid_code: assert property (
        srst_in |=> dac_code_out == {24{gamma_pkg::MID_CODE}}) else $error("codes not mid");
    a_reset_quiet: assert property (
        srst_in |=> !sda_oe_out && !otp_prog_out) else $error("outputs busy in reset");
    a_otp_one_cycle: assert property (
        disable iff (srst_in) otp_prog_out |=> !otp_prog_out) else $error("otp pulse long");
    a_sda_drive_low: assert property (
        disable iff (srst_in) sda_oe_out |-> !sda_out) else $error("sda driven high");
    a_oe_scl_low: assert property (
        disable iff (srst_in) $changed(sda_oe_out) |-> !scl_in) else $error("sda moved, scl high");
    a_ack_holds: assert property (
        disable iff (srst_in) $rose(sda_oe_out) |=> sda_oe_out [*8]) else $error("ack short");
    a_oe_settle: assert property (
        disable iff (srst_in) $changed(sda_oe_out) |=> $stable(sda_oe_out) [*6])
        else $error("sda glitch");
    // codes hold for at least 8 cycles after each move, never in bursts
    a_code_spacing: assert property (
        disable iff (srst_in) $changed(dac_code_out) |=> $stable(dac_code_out) [*8])
        else $error("codes glitch");
endmodule
bind gamma_i2c_regs gamma_i2c_regs_monitor i_mon (.clk_in(clk_in), .srst_in(srst_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .address_select_pin_in(address_select_pin_in), .dac_code_out(dac_code_out),
    .otp_prog_out(otp_prog_out));

// ===== verif/i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
    input  wire logic clk_in,      // clock
    input  wire logic sda_in,      // wire level
    output logic      scl_low_out, // pull scl low
    output logic      sda_low_out  // pull sda low
);
    // quarter bit, well above the synchroniser delay and hold need
    localparam int Q = 10;
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic set(input logic c, input logic d);
        scl_low_out <= c;
        sda_low_out <= d;
        cyc(Q);
    endtask
    task automatic start();
        set(scl_low_out, 1'b0);
        set(1'b0, 1'b0);
        set(1'b0, 1'b1);
        set(1'b1, 1'b1);
    endtask
    task automatic stop();
        set(1'b1, 1'b1);
        set(1'b0, 1'b1);
        set(1'b0, 1'b0);
    endtask
    // sda moves only with scl low; sample mid high phase
    task automatic bitx(input logic b, output logic r);
        set(1'b1, !b);
        set(1'b0, !b);
        r = sda_in;
        set(1'b0, !b);
        set(1'b1, !b);
    endtask
    task automatic byte_x(input logic [7:0] w, input logic a, output logic [7:0] r,
                          output logic k);
        for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
        bitx(a, k);
    endtask
endmodule

// ===== verif/gamma_i2c_regs_tb.sv
`timescale 1ns/100ps
module gamma_i2c_regs_tb;
    logic         clk_in = 1'b0;
    logic         srst_in = 1'b1;
    logic         sel = 1'b0;
    logic         scl_low, sda_low, sda_oe, sda_drv, otp, ack0;
    logic [239:0] codes;
    int           fails = 0, n_checks = 0, otp_n = 0;
    wire logic    scl = !scl_low;
    wire logic    sda = !(sda_low || (sda_oe && !sda_drv));
    wire logic [7:0] ad = {gamma_pkg::ADDR_HI, sel, 1'b0};
    initial forever #2 clk_in = ~clk_in;
    gamma_i2c_regs i_dut (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .address_select_pin_in(sel),
        .dac_code_out(codes), .otp_prog_out(otp));
    i2c_host_model i_host (.clk_in(clk_in), .sda_in(sda), .scl_low_out(scl_low),
        .sda_low_out(sda_low));
    always @(posedge clk_in) if (otp === 1'b1) otp_n <= otp_n + 1;
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [9:0] code(input int c);
        return codes[c*10+:10];
    endfunction
    task automatic send(input logic [7:0] q[$]);
        logic [7:0] r;
        logic       k;
        i_host.start();
        foreach (q[i]) begin
            i_host.byte_x(q[i], 1'b1, r, k);
            if (i == 0) ack0 = k;
        end
        i_host.stop();
    endtask
    task automatic t_mid();
        for (int c = 0; c < gamma_pkg::NUM_CH; c++) chk(code(c), gamma_pkg::MID_CODE);
    endtask
    task automatic t_addr();
        for (int s = 0; s < 2; s++) begin
            sel <= s[0];
            i_host.cyc(8);
            send('{{gamma_pkg::ADDR_HI, !s[0], 1'b0}});
            chk({9'h000, ack0}, 10'h001);
            send('{ad});
            chk({9'h000, ack0}, 10'h000);
        end
    endtask
    task automatic t_write();
        send('{ad, 8'h96, 8'h03, 8'hFF, 8'h01, 8'h5A});
        chk(code(22), 10'h3FF);
        chk(code(23), 10'h15A);
        // staged only: outputs must not move before apply-all
        send('{ad, 8'h00, 8'h00, 8'h44, 8'h02, 8'hB3});
        chk(code(0), gamma_pkg::MID_CODE);
        chk(code(1), gamma_pkg::MID_CODE);
        send('{ad, 8'h40});
        chk(code(0), 10'h044);
        chk(code(1), 10'h2B3);
    endtask
    task automatic t_read();
        logic [7:0] h, l;
        logic       k;
        i_host.start();
        i_host.byte_x(ad, 1'b1, h, k);
        i_host.byte_x(8'h16, 1'b1, h, k);
        i_host.start();
        i_host.byte_x(ad | 8'h01, 1'b1, h, k);
        i_host.byte_x(8'hFF, 1'b0, h, k);
        i_host.byte_x(8'hFF, 1'b0, l, k);
        chk({h[1:0], l}, 10'h3FF);
        i_host.byte_x(8'hFF, 1'b0, h, k);
        i_host.byte_x(8'hFF, 1'b1, l, k);
        chk({h[1:0], l}, 10'h15A);
        i_host.stop();
    endtask
    task automatic t_otp();
        send('{ad, 8'h20});
        chk(10'(otp_n), 10'h001);
    endtask
    task automatic t_gc();
        send('{gamma_pkg::GC_ADDR, gamma_pkg::GC_RESET});
        chk({9'h000, ack0}, 10'h000);
        t_mid();
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        i_host.cyc(4);
        t_mid();
        t_addr();
        t_write();
        t_read();
        t_otp();
        t_gc();
        final_report();
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        fails++;
        final_report();
    end
endmodule
